// ---- hdl/hall_ctrl_pkg.sv ----
// Shared constants for the iris Hall sensor control registers and serial port
package hall_ctrl_pkg;
   // Register addresses (6-bit serial address field)
   localparam logic [5:0] ADDR_BIAS_OFFSET = 6'h04;
   localparam logic [5:0] ADDR_GAIN_FILTER = 6'h05;
   localparam logic [5:0] ADDR_IRIS_CTRL   = 6'h0B;
   localparam logic [5:0] ADDR_SAMPLE      = 6'h0C;

   // Field positions inside the 16-bit data word
   localparam int BIAS_LSB      = 0;
   localparam int OFFSET_LSB    = 8;
   localparam int GAIN_LSB      = 8;
   localparam int CUTOFF_BIT    = 12;
   localparam int CLIP_LSB      = 0;
   localparam int MODE_LSB      = 4;
   localparam int POWER_BIT     = 10;
   localparam int SELFTEST_BIT  = 11;
   localparam int SAMPLE_LSB    = 0;

   // Reset values
   localparam logic [7:0] BIAS_RST     = 8'h00;
   localparam logic [7:0] OFFSET_RST   = 8'h00;
   localparam logic [3:0] GAIN_RST     = 4'h0;
   localparam logic       CUTOFF_RST   = 1'b0;
   localparam logic       POWER_RST    = 1'b0;
   localparam logic [1:0] MODE_RST     = 2'h0;
   localparam logic       SELFTEST_RST = 1'b0;
   localparam logic [3:0] CLIP_RST     = 4'h0;
   localparam logic [9:0] SAMPLE_RST   = 10'h000;

   // Mode encoding and duty scale
   localparam logic [1:0] MODE_IRIS_TEST = 2'h2;
   localparam logic [1:0] MODE_UNDEFINED = 2'h3;
   localparam logic [4:0] DUTY_FULL      = 5'h10;

   // Serial frame: 6 address bits, read flag, spare, 16 data bits, LSB first
   localparam logic [4:0] HDR_BITS   = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h18;
   localparam int         RW_BIT     = 6;

   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_HDR  = 2'b01,
      SER_DATA = 2'b11
   } ser_state_t;
endpackage : hall_ctrl_pkg

// ---- hdl/sync_2ff.sv ----
// Two-stage synchroniser for asynchronous input levels
`timescale 1ns/1ns
module sync_2ff #(
   parameter int WIDTH = 1
) (
   // Clock, reset, enable
   input  wire logic             clk_sys,
   input  wire logic             arst_n,
   input  wire logic             ce,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sync_2ff

// ---- hdl/iris_hall_sensor_control.sv ----
// Iris Hall sensor configuration and readout registers behind the serial port
// Functional notes
// - Bias current scales with code over eight
// - Offset is supply/256 times code minus 128
// - Gain code selects amplifier gain, monotonic
// - Cutoff bit selects 6.85 or 20.0 kHz
// - Power enable bit gates iris control
// - Mode 0,1 normal; 2 iris test
// - Iris test mode opens the loop
// - Max duty is 100% minus clip times 6.25%
// - Sample register is read-only ADC result
// - Sample tracks while sync high, frozen after
// - Frame sync synchronised to system clock
// - Power down stops iris analog only
`timescale 1ns/1ns
module iris_hall_sensor_control
   import hall_ctrl_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       ce,
   // Serial register port pins
   input  wire logic       ser_cs,
   input  wire logic       ser_clk,
   input  wire logic       ser_din,
   output logic            ser_dout,
   output logic            ser_dout_oe,
   // Frame sync pin and ADC result
   input  wire logic       iris_frame_sync,
   input  wire logic [9:0] adc_result,
   // Analog front end controls
   output logic      [7:0] hall_bias_current_code,
   output logic      [7:0] amp_offset_code,
   output logic      [3:0] amp_gain_code,
   output logic            filter_cutoff_select,
   output logic            iris_power_enable,
   output logic            iris_analog_enable,
   output logic      [1:0] adc_source_mode,
   output logic            iris_loop_open,
   output logic            adc_selftest_enable,
   output logic      [3:0] max_duty_clip,
   output logic      [4:0] max_duty_sixteenths,
   output logic      [9:0] iris_position_sample
);
   // Synchronised pins
   logic cs_s, sclk_s, din_s, fs_s;

   sync_2ff #(.WIDTH(4)) u_sync (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .ce       (ce),
      .async_in ({ser_cs, ser_clk, ser_din, iris_frame_sync}),
      .sync_out ({cs_s, sclk_s, din_s, fs_s})
   );

   // Serial engine state
   ser_state_t  st_q, st_d;
   logic        sclk_q, sclk_d;
   logic [4:0]  cnt_q, cnt_d;
   logic [23:0] sh_q, sh_d;
   logic [15:0] out_q, out_d;
   logic        dout_q, dout_d;
   logic        rd_q, rd_d;
   logic        wr_stb;

   // Register state
   logic [7:0] bias_q, bias_d, offs_q, offs_d;
   logic [3:0] gain_q, gain_d, clip_q, clip_d;
   logic       cut_q, cut_d, pwr_q, pwr_d, test_q, test_d;
   logic [1:0] mode_q, mode_d;
   logic [9:0] smp_q, smp_d;

   wire sclk_rise = sclk_s & ~sclk_q;
   wire sclk_fall = ~sclk_s & sclk_q;

   function automatic logic [15:0] read_word(input logic [5:0] a);
      logic [15:0] w;
      w = 16'h0000;
      case (a)
         ADDR_BIAS_OFFSET: begin
            w[BIAS_LSB +: 8]   = bias_q;
            w[OFFSET_LSB +: 8] = offs_q;
         end
         ADDR_GAIN_FILTER: begin
            w[GAIN_LSB +: 4] = gain_q;
            w[CUTOFF_BIT]    = cut_q;
         end
         ADDR_IRIS_CTRL: begin
            w[CLIP_LSB +: 4] = clip_q;
            w[MODE_LSB +: 2] = mode_q;
            w[POWER_BIT]     = pwr_q;
            w[SELFTEST_BIT]  = test_q;
         end
         ADDR_SAMPLE: w[SAMPLE_LSB +: 10] = smp_q;
         default: w = 16'h0000;
      endcase
      return w;
   endfunction : read_word

   // Serial frame sequencing
   always_comb begin
      st_d   = st_q;
      sclk_d = sclk_s;
      cnt_d  = cnt_q;
      sh_d   = sh_q;
      out_d  = out_q;
      dout_d = dout_q;
      rd_d   = rd_q;
      wr_stb = 1'b0;
      if (!cs_s) begin
         // Deasserted select aborts any partial frame
         st_d  = SER_IDLE;
         cnt_d = 5'h00;
      end else begin
         case (st_q)
            SER_IDLE: st_d = SER_HDR;
            SER_HDR: begin
               if (sclk_rise) begin
                  sh_d  = {din_s, sh_q[23:1]};
                  cnt_d = cnt_q + 5'h01;
                  if (cnt_q + 5'h01 == HDR_BITS) begin
                     st_d   = SER_DATA;
                     out_d  = read_word(sh_d[21:16]);
                     // Latched: header bits keep shifting through sh_q
                     rd_d   = sh_d[16 + RW_BIT];
                  end
               end
            end
            SER_DATA: begin
               if (sclk_fall && rd_q) begin
                  dout_d = out_q[0];
                  out_d  = {1'b0, out_q[15:1]};
               end
               if (sclk_rise && cnt_q != FRAME_BITS) begin
                  sh_d  = {din_s, sh_q[23:1]};
                  cnt_d = cnt_q + 5'h01;
                  wr_stb = (cnt_q + 5'h01 == FRAME_BITS) && !rd_q;
               end
            end
            default: st_d = SER_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q   <= SER_IDLE;
         sclk_q <= 1'b0;
         cnt_q  <= 5'h00;
         sh_q   <= 24'h000000;
         out_q  <= 16'h0000;
         dout_q <= 1'b0;
         rd_q   <= 1'b0;
      end else if (ce) begin
         st_q   <= st_d;
         sclk_q <= sclk_d;
         cnt_q  <= cnt_d;
         sh_q   <= sh_d;
         out_q  <= out_d;
         dout_q <= dout_d;
         rd_q   <= rd_d;
      end
   end

   // Register writes; sh_d holds the full frame when wr_stb fires
   always_comb begin
      bias_d = bias_q;
      offs_d = offs_q;
      gain_d = gain_q;
      cut_d  = cut_q;
      pwr_d  = pwr_q;
      mode_d = mode_q;
      test_d = test_q;
      clip_d = clip_q;
      smp_d  = smp_q;
      if (wr_stb) begin
         case (sh_d[5:0])
            ADDR_BIAS_OFFSET: begin
               bias_d = sh_d[8 + BIAS_LSB +: 8];
               offs_d = sh_d[8 + OFFSET_LSB +: 8];
            end
            ADDR_GAIN_FILTER: begin
               gain_d = sh_d[8 + GAIN_LSB +: 4];
               cut_d  = sh_d[8 + CUTOFF_BIT];
            end
            ADDR_IRIS_CTRL: begin
               clip_d = sh_d[8 + CLIP_LSB +: 4];
               mode_d = sh_d[8 + MODE_LSB +: 2];
               pwr_d  = sh_d[8 + POWER_BIT];
               test_d = sh_d[8 + SELFTEST_BIT];
            end
            // Sample address is read-only: write dropped
            default: ;
         endcase
      end
      // Track ADC while sync high; hold from its fall
      if (fs_s) begin
         smp_d = adc_result;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bias_q <= BIAS_RST;
         offs_q <= OFFSET_RST;
         gain_q <= GAIN_RST;
         cut_q  <= CUTOFF_RST;
         pwr_q  <= POWER_RST;
         mode_q <= MODE_RST;
         test_q <= SELFTEST_RST;
         clip_q <= CLIP_RST;
         smp_q  <= SAMPLE_RST;
      end else if (ce) begin
         bias_q <= bias_d;
         offs_q <= offs_d;
         gain_q <= gain_d;
         cut_q  <= cut_d;
         pwr_q  <= pwr_d;
         mode_q <= mode_d;
         test_q <= test_d;
         clip_q <= clip_d;
         smp_q  <= smp_d;
      end
   end

   // Output data only during the data phase of a read
   assign ser_dout    = dout_q;
   assign ser_dout_oe = (st_q == SER_DATA) && rd_q;

   assign hall_bias_current_code = bias_q;
   assign amp_offset_code        = offs_q;
   assign amp_gain_code          = gain_q;
   assign filter_cutoff_select   = cut_q;
   assign iris_power_enable      = pwr_q;
   // Only iris analog gated; stepper driver has no tie here
   assign iris_analog_enable     = pwr_q;
   assign adc_source_mode        = mode_q;
   assign iris_loop_open         = (mode_q == MODE_IRIS_TEST);
   assign adc_selftest_enable    = test_q;
   assign max_duty_clip          = clip_q;
   assign max_duty_sixteenths    = DUTY_FULL - {1'b0, clip_q};
   assign iris_position_sample   = smp_q;
endmodule : iris_hall_sensor_control

// ---- test/iris_hall_sensor_control_properties.sv ----
// Port assertions for the Hall sensor control block
`timescale 1ns/1ns
module iris_hall_sensor_control_properties (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic ser_cs,
   input wire logic ser_dout_oe,
   input wire logic iris_frame_sync,
   input wire logic [9:0] adc_result,
   input wire logic [7:0] hall_bias_current_code,
   input wire logic [3:0] amp_gain_code,
   input wire logic iris_power_enable,
   input wire logic iris_analog_enable,
   input wire logic [1:0] adc_source_mode,
   input wire logic iris_loop_open,
   input wire logic [3:0] max_duty_clip,
   input wire logic [4:0] max_duty_sixteenths,
   input wire logic [9:0] iris_position_sample
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_duty_from_clip: assert property (max_duty_sixteenths == 5'h10 - {1'b0, max_duty_clip})
      else $error("duty limit off");
   a_loop_open_mode: assert property (iris_loop_open == (adc_source_mode == 2'h2))
      else $error("loop open wrong");
   a_analog_follows: assert property (iris_analog_enable == iris_power_enable)
      else $error("analog enable wrong");
   a_reset_clear: assert property ($rose(arst_n) |-> hall_bias_current_code == 8'h00 &&
      amp_gain_code == 4'h0 && max_duty_clip == 4'h0 && !iris_power_enable) else $error("reset value");
   a_cfg_quiet: assert property (!ser_cs [*6] |=> $stable(hall_bias_current_code) &&
      $stable(amp_gain_code) && $stable(max_duty_clip)) else $error("config moved");
   a_oe_released: assert property (!ser_cs [*5] |-> !ser_dout_oe)
      else $error("output driven idle");
   a_sample_frozen: assert property (!iris_frame_sync [*5] |=> $stable(iris_position_sample))
      else $error("sample moved");
   a_sample_tracks: assert property (iris_frame_sync [*5] ##0 ce |=>
      iris_position_sample == $past(adc_result)) else $error("sample not tracking");
endmodule : iris_hall_sensor_control_properties

// ---- test/hall_host_model.sv ----
// Serial host model framing register reads and writes
`timescale 1ns/1ns
module hall_host_model (
   input  wire logic clk_sys,
   input  wire logic ser_dout,
   input  wire logic ser_dout_oe,
   output logic ser_cs,
   output logic ser_clk,
   output logic ser_din,
   output logic [15:0] rdata,
   output logic rdone
);
   initial begin
      ser_cs = 1'b0;
      ser_clk = 1'b0;
      ser_din = 1'b0;
      rdata = 16'h0000;
      rdone = 1'b0;
   end
   // Six clocks a phase leaves margin over the pin synchronisers
   task automatic xfer(input logic rd, input logic [5:0] a, input logic [15:0] wd, input int n);
      logic [23:0] f;
      f = {wd, 1'b0, rd, a};
      ser_cs = 1'b1;
      for (int i = 0; i < n; i++) begin
         ser_din = f[i];
         repeat (6) @(negedge clk_sys);
         if (i > 7)
            // Undriven line shows the inverse, so a dropped enable is caught
            rdata[i-8] = ser_dout_oe ? ser_dout : ~ser_dout;
         ser_clk = 1'b1;
         repeat (6) @(negedge clk_sys);
         ser_clk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      ser_cs = 1'b0;
      // Released line must not keep showing the last bit
      ser_din = ~ser_din;
      rdone = rd;
      @(negedge clk_sys);
      rdone = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask : xfer
endmodule : hall_host_model

// ---- test/iris_hall_sensor_control_tb_top.sv ----
// Self-checking bench for the Hall sensor control block
`timescale 1ns/1ns
module iris_hall_sensor_control_tb_top;
   import hall_ctrl_pkg::*;
   logic clk_sys = 1'b0, arst_n = 1'b0, ce = 1'b1, iris_frame_sync = 1'b0;
   logic [9:0] adc_result = 10'h000, iris_position_sample, es;
   logic ser_cs, ser_clk, ser_din, ser_dout, ser_dout_oe, rdone, filter_cutoff_select;
   logic iris_power_enable, iris_analog_enable, iris_loop_open, adc_selftest_enable;
   logic [7:0] hall_bias_current_code, amp_offset_code;
   logic [3:0] amp_gain_code, max_duty_clip;
   logic [1:0] adc_source_mode;
   logic [4:0] max_duty_sixteenths;
   logic [15:0] rdata, d, q[$];
   logic [5:0] ad [3] = '{ADDR_BIAS_OFFSET, ADDR_GAIN_FILTER, ADDR_IRIS_CTRL};
   // Self-test bit kept clear on purpose
   logic [15:0] mk [3] = '{16'hFFFF, 16'h1F00, 16'h043F};
   int seed = 32'h5678;
   int err_total = 0;
   int compares = 0;
   always #20 clk_sys = ~clk_sys;
   hall_host_model i_host (.*);
   iris_hall_sensor_control i_dut (.*);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [15:0] v);
      i_host.xfer(1'b0, a, v, 24);
   endtask : wr
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      q.push_back(e);
      i_host.xfer(1'b1, a, 16'h0000, 24);
   endtask : rd
   function automatic logic [15:0] obs(input int k);
      case (k)
         0: obs = {amp_offset_code, hall_bias_current_code};
         1: obs = {3'h0, filter_cutoff_select, amp_gain_code, 8'h00};
         default: obs = {4'h0, adc_selftest_enable, iris_power_enable, 4'h0, adc_source_mode, max_duty_clip};
      endcase
   endfunction : obs
   task automatic stop_test;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   always @(posedge clk_sys) begin
      if (rdone && q.size() > 0)
         chk(rdata, q.pop_front());
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      err_total++;
      stop_test();
   end
   initial begin
      repeat (8) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      for (int k = 0; k < 3; k++) rd(ad[k], 16'h0000);
      chk({11'h000, max_duty_sixteenths}, 16'h0010);
      wr(ADDR_BIAS_OFFSET, 16'h8020);
      wr(ADDR_GAIN_FILTER, 16'h0700);
      wr(ADDR_BIAS_OFFSET, 16'h7D24);
      chk(obs(0), 16'h7D24);
      for (int r = 0; r < 9; r++) begin
         d = 16'($random(seed)) & mk[r%3];
         wr(ad[r%3], d);
         chk(obs(r%3), d);
         rd(ad[r%3], d);
      end
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_IRIS_CTRL, 16'(16'h0400 | (m << 4) | (m * 5)));
         chk({iris_loop_open, iris_analog_enable, 9'h000, max_duty_sixteenths},
             {m == 2, 1'b1, 9'h000, 5'(16 - m * 5)});
      end
      repeat (8) begin
         @(negedge clk_sys);
         iris_frame_sync = 1'b1;
         adc_result = 10'($random(seed));
      end
      es = adc_result;
      iris_frame_sync = 1'b0;
      repeat (5) @(negedge clk_sys);
      adc_result = ~es;
      wr(ADDR_SAMPLE, 16'hFFFF);
      rd(ADDR_SAMPLE, {6'h00, es});
      chk({6'h00, iris_position_sample}, {6'h00, es});
      // Enable low must freeze the sample despite sync high
      ce = 1'b0;
      iris_frame_sync = 1'b1;
      adc_result = 10'($random(seed));
      repeat (6) @(negedge clk_sys);
      chk({6'h00, iris_position_sample}, {6'h00, es});
      iris_frame_sync = 1'b0;
      repeat (2) @(negedge clk_sys);
      ce = 1'b1;
      repeat (4) @(negedge clk_sys);
      wr(6'h3F, 16'hFFFF);
      rd(6'h3F, 16'h0000);
      d = obs(0);
      i_host.xfer(1'b0, ADDR_BIAS_OFFSET, ~d, 20);
      rd(ADDR_BIAS_OFFSET, d);
      arst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      arst_n = 1'b1;
      repeat (4) @(negedge clk_sys);
      for (int k = 0; k < 3; k++) rd(ad[k], 16'h0000);
      stop_test();
   end
endmodule : iris_hall_sensor_control_tb_top
bind iris_hall_sensor_control iris_hall_sensor_control_properties i_props (.*);
